// >>> design/synth_cfg_pkg.sv
package synth_cfg_pkg;

	// ------------------------------------------------------------
	// Bus shape and answers
	// ------------------------------------------------------------
	localparam int         ADDR_W      = 12;
	localparam int         DATA_W      = 32;
	localparam int         IDX_LSB     = 2;
	localparam int         IDX_MSB     = 8;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Register indexes (byte address is four times the index)
	// ------------------------------------------------------------
	localparam int         REG_FIRST          = 'h28;
	localparam int         REG_LAST           = 'h6f;
	localparam logic [6:0] IDX_LOCK_STATE     = 7'h28;
	localparam logic [6:0] IDX_RSVD_29        = 7'h29;
	localparam logic [6:0] IDX_PROG_GATE      = 7'h36;
	localparam logic [6:0] IDX_PROG_RUN       = 7'h37;
	localparam logic [6:0] IDX_PROG_MULT_LO   = 7'h38;
	localparam logic [6:0] IDX_PROG_MULT_HI   = 7'h39;
	localparam logic [6:0] IDX_PROG_CLK_PHASE = 7'h3a;
	localparam logic [6:0] IDX_PROG_FINE      = 7'h3d;
	localparam logic [6:0] IDX_PROG_RATE      = 7'h3e;
	localparam logic [6:0] IDX_PROG_STYLE     = 7'h3f;
	localparam logic [6:0] IDX_PROG_PDLY_LO   = 7'h40;
	localparam logic [6:0] IDX_PROG_PDLY_HI   = 7'h41;
	localparam logic [6:0] IDX_PROG_PCOARSE   = 7'h42;
	localparam logic [6:0] IDX_SDH_GATE       = 7'h50;
	localparam logic [6:0] IDX_SDH_RUN        = 7'h51;
	localparam logic [6:0] IDX_SDH_DIV        = 7'h52;
	localparam logic [6:0] IDX_SDH_CLK_PHASE  = 7'h53;
	localparam logic [6:0] IDX_SDH_FINE       = 7'h55;
	localparam logic [6:0] IDX_SDH_RATE       = 7'h56;
	localparam logic [6:0] IDX_SDH_STYLE      = 7'h57;
	localparam logic [6:0] IDX_SDH_PDLY_LO    = 7'h58;
	localparam logic [6:0] IDX_SDH_PDLY_HI    = 7'h59;
	localparam logic [6:0] IDX_SDH_PCOARSE    = 7'h5a;
	localparam logic [6:0] IDX_DIFF_CTRL      = 7'h60;
	localparam logic [6:0] IDX_DIFF_RATE      = 7'h61;
	localparam logic [6:0] IDX_FB_FINE        = 7'h63;
	localparam logic [6:0] IDX_MODE_SELECT    = 7'h65;
	localparam logic [6:0] IDX_CA_MULT_LO     = 7'h67;
	localparam logic [6:0] IDX_CA_MULT_HI     = 7'h68;
	localparam logic [6:0] IDX_CA_SCM_LO      = 7'h69;
	localparam logic [6:0] IDX_CA_SCM_HI      = 7'h6a;
	localparam logic [6:0] IDX_CA_CFM_LO_B0   = 7'h6b;
	localparam logic [6:0] IDX_CA_CFM_LO_B1   = 7'h6c;
	localparam logic [6:0] IDX_CA_CFM_HI_B0   = 7'h6d;
	localparam logic [6:0] IDX_CA_CFM_HI_B1   = 7'h6e;
	localparam logic [6:0] IDX_CA_CYCLES      = 7'h6f;

	// ------------------------------------------------------------
	// Reset values: the zero default and those that are not zero
	// ------------------------------------------------------------
	localparam logic [7:0] RST_ZERO       = 8'h00;
	localparam logic [7:0] RST_LOCK_STATE = 8'h04;
	localparam logic [7:0] RST_RSVD_29    = 8'h03;
	localparam logic [7:0] RST_GATE       = 8'h8f;
	localparam logic [7:0] RST_RUN        = 8'h0f;
	localparam logic [7:0] RST_PROG_MULT_HI = 8'h01;
	localparam logic [7:0] RST_PULSE_RATE = 8'h05;
	localparam logic [7:0] RST_PROG_STYLE = 8'h83;
	localparam logic [7:0] RST_SDH_DIV    = 8'h42;
	localparam logic [7:0] RST_SDH_STYLE  = 8'h23;
	localparam logic [7:0] RST_DIFF_CTRL  = 8'ha3;
	localparam logic [7:0] RST_DIFF_RATE  = 8'h53;
	localparam logic [7:0] RST_FB_FINE    = 8'hf5;

	// ------------------------------------------------------------
	// Field positions and step sizes
	// ------------------------------------------------------------
	localparam int  CLK_BIT        = 0;
	localparam int  PULSE_BIT      = 1;
	localparam int  DIFF_EN_BIT    = 0;
	localparam int  MULT_HI_W      = 6;
	localparam int  REF_COUNT      = 3;
	localparam int  STAT_LOCK_BIT  = 0;
	localparam int  STAT_HOLD_BIT  = 1;
	localparam int  STAT_FREE_BIT  = 2;
	localparam real PROG_STEP_MHZ  = 262.14;
	localparam real SDH_STEP_MHZ   = 311.04;
	localparam int  COARSE_STEP_KHZ = 8;

	typedef enum logic [1:0] {MODE_AUTO, MODE_CUSTOM_A, MODE_CUSTOM_B} refMode_t;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic              awvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              wvalid;
		logic              bready;
		logic [ADDR_W-1:0] araddr;
		logic              arvalid;
		logic              rready;
	} axiReq_t;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
	} axiRsp_t;

	typedef struct packed {
		logic [13:0] progMultiplier;
		logic [7:0]  progClkPhase;
		logic [7:0]  progFineAlign;
		logic [7:0]  progPulseRate;
		logic [7:0]  progPulseStyle;
		logic [15:0] progPulseFine;
		logic [7:0]  progPulseCoarse;
		logic [7:0]  sdhDivider;
		logic [7:0]  sdhClkPhase;
		logic [7:0]  sdhFineAlign;
		logic [7:0]  sdhPulseRate;
		logic [7:0]  sdhPulseStyle;
		logic [15:0] sdhPulseFine;
		logic [7:0]  sdhPulseCoarse;
		logic [7:0]  diffRate;
		logic [7:0]  fbFineAlign;
		logic [13:0] custAMultiplier;
		logic [7:0]  custAScmLow;
		logic [7:0]  custAScmHigh;
		logic [15:0] custACfmLow;
		logic [15:0] custACfmHigh;
	} synthConfig_t;

	typedef struct packed {
		logic progClk;
		logic progPulse;
		logic sdhClk;
		logic sdhPulse;
		logic diffClk;
	} outputDrive_t;

	// Locations that answer on the bus
	function automatic logic isMapped(input logic [6:0] idx);
		return idx == IDX_LOCK_STATE || idx == IDX_RSVD_29
			|| (idx >= IDX_PROG_GATE && idx <= IDX_PROG_CLK_PHASE)
			|| (idx >= IDX_PROG_FINE && idx <= IDX_PROG_PCOARSE)
			|| (idx >= IDX_SDH_GATE && idx <= IDX_SDH_CLK_PHASE)
			|| (idx >= IDX_SDH_FINE && idx <= IDX_SDH_PCOARSE)
			|| idx == IDX_DIFF_CTRL || idx == IDX_DIFF_RATE || idx == IDX_FB_FINE
			|| idx == IDX_MODE_SELECT || (idx >= IDX_CA_MULT_LO && idx <= IDX_CA_CYCLES);
	endfunction

	// Value each location takes at reset
	function automatic logic [7:0] regReset(input logic [6:0] idx);
		case (idx)
			IDX_LOCK_STATE:               return RST_LOCK_STATE;
			IDX_RSVD_29:                  return RST_RSVD_29;
			IDX_PROG_GATE, IDX_SDH_GATE:  return RST_GATE;
			IDX_PROG_RUN, IDX_SDH_RUN:    return RST_RUN;
			IDX_PROG_MULT_HI:             return RST_PROG_MULT_HI;
			IDX_PROG_RATE, IDX_SDH_RATE:  return RST_PULSE_RATE;
			IDX_PROG_STYLE:               return RST_PROG_STYLE;
			IDX_SDH_DIV:                  return RST_SDH_DIV;
			IDX_SDH_STYLE:                return RST_SDH_STYLE;
			IDX_DIFF_CTRL:                return RST_DIFF_CTRL;
			IDX_DIFF_RATE:                return RST_DIFF_RATE;
			IDX_FB_FINE:                  return RST_FB_FINE;
			default:                      return RST_ZERO;
		endcase
	endfunction

endpackage

// >>> design/level_sync.sv
`timescale 1ns/1ps
module level_sync
	import synth_cfg_pkg::*;
#(
	parameter int WIDTH = 1
)(
	input  wire logic             clk_sys,
	input  wire logic             clearN,
	input  wire logic [WIDTH-1:0] levelIn,
	output logic      [WIDTH-1:0] levelOut
);

	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} syncState_t;

	syncState_t state_q;
	syncState_t state_d;

	// Two stages; the first is read only by the second
	always_comb begin
		state_d = state_q;
		state_d.first = levelIn;
		state_d.second = state_q.first;
	end

	always_ff @(posedge clk_sys or negedge clearN) begin
		if (!clearN) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign levelOut = state_q.second;

endmodule

// >>> design/synth_output_config_regs.sv
`timescale 1ns/1ps
// How it works
// R1 - Programmable clock is N times 8 kHz
// R2 - Programmable pulse fine delay, sixteen bits
// R3 - SDH pulse fine delay, sixteen bits
// R4 - Coarse pulse delay in 8 kHz cycles
// R5 - Programmable outputs driven only when enabled
// R6 - Programmable run register starts generation
// R7 - SDH enable and run gate outputs
// R8 - SDH divider selects clock, resets 42
// R9 - Coarse clock phase per path, resets zero
// R10 - Fine alignment per path and feedback
// R11 - Per-path pulse rate and pulse style
// R12 - Differential clock enable and rate select
// R13 - Read-only lock and holdover status
// R14 - Per-reference auto, custom A, custom B
// R15 - Custom A fourteen-bit N multiplier
// R16 - Custom A single-cycle and frequency low limits
// R17 - Host leaves reserved locations at default
// R18 - Custom A high limit and cycles minus one
module synth_output_config_regs
	import synth_cfg_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 resetn,
	input  wire axiReq_t              axiReq,
	output axiRsp_t                   axiRsp,
	input  wire logic                 lockedPin,
	input  wire logic                 holdoverPin,
	output synthConfig_t              synthConfig,
	output outputDrive_t              outputDrive,
	output logic [2*REF_COUNT-1:0]    refModeSel,
	output logic                      customAInUse,
	output logic [8:0]                monitorCycles
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [0:0] {WR_IDLE, WR_RESP} wrState_t;
	typedef enum logic [0:0] {RD_IDLE, RD_DATA} rdState_t;

	typedef struct packed {
		wrState_t                     wrState;
		rdState_t                     rdState;
		logic                         haveAddr;
		logic                         haveData;
		logic [6:0]                   wrIndex;
		logic                         wrUpperOk;
		logic [7:0]                   wrByte;
		logic                         wrLane;
		axiRsp_t                      rsp;
		logic [REG_LAST:REG_FIRST][7:0] regFile;
		outputDrive_t                 drive;
		logic [2*REF_COUNT-1:0]       refMode;
		logic                         custAUsed;
		logic [8:0]                   cycles;
	} state_t;

	// Reset image of the whole state
	function automatic state_t resetState();
		state_t s;
		s = '0;
		s.rsp.awready = 1'b1;
		s.rsp.wready = 1'b1;
		s.rsp.arready = 1'b1;
		for (int i = REG_FIRST; i <= REG_LAST; i++) begin
			s.regFile[i] = regReset(7'(i));
		end
		s.drive.progClk = RST_GATE[CLK_BIT] & RST_RUN[CLK_BIT];
		s.drive.progPulse = RST_GATE[PULSE_BIT] & RST_RUN[PULSE_BIT];
		s.drive.sdhClk = RST_GATE[CLK_BIT] & RST_RUN[CLK_BIT];
		s.drive.sdhPulse = RST_GATE[PULSE_BIT] & RST_RUN[PULSE_BIT];
		s.drive.diffClk = RST_DIFF_CTRL[DIFF_EN_BIT];
		s.cycles = 9'(RST_ZERO) + 9'h1;
		return s;
	endfunction

	localparam state_t STATE_RESET = resetState();

	state_t                 state_q;
	state_t                 state_d;
	logic                   resetSyncN;
	logic [1:0]             statusSync;
	logic [2*REF_COUNT-1:0] modeDecoded;

	// ------------------------------------------------------------
	// Reset release and pin synchronisers
	// ------------------------------------------------------------

	// Reset asserts at once and releases after two edges
	level_sync #(
		.WIDTH (1)
	) resetRelease (
		.clk_sys  (clk_sys),
		.clearN   (resetn),
		.levelIn  (1'b1),
		.levelOut (resetSyncN)
	);

	// Lock and holdover levels come from the loop's own domain
	level_sync #(
		.WIDTH (2)
	) statusPins (
		.clk_sys  (clk_sys),
		.clearN   (resetSyncN),
		.levelIn  ({holdoverPin, lockedPin}),
		.levelOut (statusSync)
	);

	// ------------------------------------------------------------
	// Per-reference monitor mode decode
	// ------------------------------------------------------------
	genvar r;
	generate
		for (r = 0; r < REF_COUNT; r++) begin : refDecode
			logic [1:0] field;
			refMode_t   mode;
			assign field = state_q.regFile[IDX_MODE_SELECT][2*r+1:2*r];
			// Unused code three falls back to auto detection
			always_comb begin
				case (field)
					2'h1:    mode = MODE_CUSTOM_A;
					2'h2:    mode = MODE_CUSTOM_B;
					default: mode = MODE_AUTO;
				endcase
			end
			assign modeDecoded[2*r+1:2*r] = mode; // R14
		end
	endgenerate

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic       awTake;
		logic       wTake;
		logic       arTake;
		logic       wrOk;
		logic       rdOk;
		logic [6:0] rdIndex;
		logic       anyA;
		awTake = 1'b0;
		wTake = 1'b0;
		arTake = 1'b0;
		wrOk = 1'b0;
		rdOk = 1'b0;
		rdIndex = '0;
		anyA = 1'b0;
		state_d = state_q;

		// A channel moves when valid meets ready
		awTake = axiReq.awvalid & state_q.rsp.awready;
		wTake = axiReq.wvalid & state_q.rsp.wready;
		arTake = axiReq.arvalid & state_q.rsp.arready;

		// Capture address and data in whichever order they come
		if (awTake) begin
			state_d.haveAddr = 1'b1;
			state_d.wrIndex = axiReq.awaddr[IDX_MSB:IDX_LSB];
			state_d.wrUpperOk =
				axiReq.awaddr[ADDR_W-1:IDX_MSB+1] == '0;
		end
		if (wTake) begin
			state_d.haveData = 1'b1;
			state_d.wrByte = axiReq.wdata[7:0];
			state_d.wrLane = axiReq.wstrb[0];
		end

		// Write commit and response
		case (state_q.wrState)
			WR_IDLE: begin
				if (state_d.haveAddr && state_d.haveData) begin
					// Status is read-only; writes there are refused
					wrOk =
						state_d.wrUpperOk && isMapped(state_d.wrIndex)
						&& state_d.wrIndex != IDX_LOCK_STATE; // R13
					if (wrOk && state_d.wrLane) begin
						state_d.regFile[state_d.wrIndex] = state_d.wrByte;
					end
					state_d.rsp.bvalid = 1'b1;
					state_d.rsp.bresp =
						wrOk ? RESP_OKAY : RESP_SLVERR;
					state_d.haveAddr = 1'b0;
					state_d.haveData = 1'b0;
					state_d.wrState = WR_RESP;
				end
			end
			WR_RESP: begin
				if (axiReq.bready) begin
					state_d.rsp.bvalid = 1'b0;
					state_d.wrState = WR_IDLE;
				end
			end
			default: begin
				state_d.wrState = WR_IDLE;
			end
		endcase
		state_d.rsp.awready =
			!state_d.haveAddr && state_d.wrState == WR_IDLE;
		state_d.rsp.wready =
			!state_d.haveData && state_d.wrState == WR_IDLE;

		// Read answer; unmapped locations read zero with an error
		case (state_q.rdState)
			RD_IDLE: begin
				if (arTake) begin
					rdIndex = axiReq.araddr[IDX_MSB:IDX_LSB];
					rdOk =
						axiReq.araddr[ADDR_W-1:IDX_MSB+1] == '0 && isMapped(rdIndex);
					state_d.rsp.rdata =
						rdOk ? {24'h0, state_q.regFile[rdIndex]} : '0;
					state_d.rsp.rresp =
						rdOk ? RESP_OKAY : RESP_SLVERR;
					state_d.rsp.rvalid = 1'b1;
					state_d.rdState = RD_DATA;
				end
			end
			RD_DATA: begin
				if (axiReq.rready) begin
					state_d.rsp.rvalid = 1'b0;
					state_d.rdState = RD_IDLE;
				end
			end
			default: begin
				state_d.rdState = RD_IDLE;
			end
		endcase
		state_d.rsp.arready =
			state_d.rdState == RD_IDLE;

		// Lock, holdover and free-run view of the loop
		state_d.regFile[IDX_LOCK_STATE] = '0;
		state_d.regFile[IDX_LOCK_STATE][STAT_LOCK_BIT] =
			statusSync[0]; // R13
		state_d.regFile[IDX_LOCK_STATE][STAT_HOLD_BIT] =
			statusSync[1]; // R13
		state_d.regFile[IDX_LOCK_STATE][STAT_FREE_BIT] =
			!statusSync[0] && !statusSync[1]; // R13

		// Output drive: enable gates, run starts generation
		state_d.drive.progClk = state_q.regFile[IDX_PROG_GATE][CLK_BIT]
			& state_q.regFile[IDX_PROG_RUN][CLK_BIT]; // R5 R6
		state_d.drive.progPulse = state_q.regFile[IDX_PROG_GATE][PULSE_BIT]
			& state_q.regFile[IDX_PROG_RUN][PULSE_BIT]; // R5 R6
		state_d.drive.sdhClk = state_q.regFile[IDX_SDH_GATE][CLK_BIT]
			& state_q.regFile[IDX_SDH_RUN][CLK_BIT]; // R7
		state_d.drive.sdhPulse = state_q.regFile[IDX_SDH_GATE][PULSE_BIT]
			& state_q.regFile[IDX_SDH_RUN][PULSE_BIT]; // R7
		state_d.drive.diffClk =
			state_q.regFile[IDX_DIFF_CTRL][DIFF_EN_BIT]; // R12

		// Monitor mode per reference and custom A usage
		state_d.refMode = modeDecoded; // R14
		for (int i = 0; i < REF_COUNT; i++) begin
			if (modeDecoded[2*i +: 2] == MODE_CUSTOM_A) begin
				anyA = 1'b1;
			end
		end
		state_d.custAUsed = anyA; // R15

		// Stored value is monitoring cycles minus one
		state_d.cycles =
			9'(state_q.regFile[IDX_CA_CYCLES]) + 9'h1; // R18
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetSyncN) begin
		if (!resetSyncN) begin
			state_q <= STATE_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all straight from state
	// ------------------------------------------------------------
	assign axiRsp = state_q.rsp;
	assign outputDrive = state_q.drive;
	assign refModeSel = state_q.refMode;
	assign customAInUse = state_q.custAUsed;
	assign monitorCycles = state_q.cycles;

	// Programmable path settings
	assign synthConfig.progMultiplier =
		{state_q.regFile[IDX_PROG_MULT_HI][MULT_HI_W-1:0],
		state_q.regFile[IDX_PROG_MULT_LO]}; // R1
	assign synthConfig.progClkPhase =
		state_q.regFile[IDX_PROG_CLK_PHASE]; // R9
	assign synthConfig.progFineAlign =
		state_q.regFile[IDX_PROG_FINE]; // R10
	assign synthConfig.progPulseRate =
		state_q.regFile[IDX_PROG_RATE]; // R11
	assign synthConfig.progPulseStyle =
		state_q.regFile[IDX_PROG_STYLE]; // R11
	assign synthConfig.progPulseFine =
		{state_q.regFile[IDX_PROG_PDLY_HI],
		state_q.regFile[IDX_PROG_PDLY_LO]}; // R2
	assign synthConfig.progPulseCoarse =
		state_q.regFile[IDX_PROG_PCOARSE]; // R4

	// SDH path settings
	assign synthConfig.sdhDivider =
		state_q.regFile[IDX_SDH_DIV]; // R8
	assign synthConfig.sdhClkPhase =
		state_q.regFile[IDX_SDH_CLK_PHASE]; // R9
	assign synthConfig.sdhFineAlign =
		state_q.regFile[IDX_SDH_FINE]; // R10
	assign synthConfig.sdhPulseRate =
		state_q.regFile[IDX_SDH_RATE]; // R11
	assign synthConfig.sdhPulseStyle =
		state_q.regFile[IDX_SDH_STYLE]; // R11
	assign synthConfig.sdhPulseFine =
		{state_q.regFile[IDX_SDH_PDLY_HI],
		state_q.regFile[IDX_SDH_PDLY_LO]}; // R3
	assign synthConfig.sdhPulseCoarse =
		state_q.regFile[IDX_SDH_PCOARSE]; // R4

	// Differential output and feedback alignment
	assign synthConfig.diffRate =
		state_q.regFile[IDX_DIFF_RATE]; // R12
	assign synthConfig.fbFineAlign =
		state_q.regFile[IDX_FB_FINE]; // R10

	// Custom monitoring configuration A
	assign synthConfig.custAMultiplier =
		{state_q.regFile[IDX_CA_MULT_HI][MULT_HI_W-1:0],
		state_q.regFile[IDX_CA_MULT_LO]}; // R15
	assign synthConfig.custAScmLow =
		state_q.regFile[IDX_CA_SCM_LO]; // R16
	assign synthConfig.custAScmHigh =
		state_q.regFile[IDX_CA_SCM_HI]; // R16
	assign synthConfig.custACfmLow =
		{state_q.regFile[IDX_CA_CFM_LO_B1],
		state_q.regFile[IDX_CA_CFM_LO_B0]}; // R16
	assign synthConfig.custACfmHigh =
		{state_q.regFile[IDX_CA_CFM_HI_B1],
		state_q.regFile[IDX_CA_CFM_HI_B0]}; // R18

endmodule

// >>> tb/synth_output_config_regs_properties.sv
`timescale 1ns/1ps
module synth_output_config_regs_checker
	import synth_cfg_pkg::*;
(
	input wire logic                   clk_sys,
	input wire logic                   resetn,
	input wire axiReq_t                axiReq,
	input wire axiRsp_t                axiRsp,
	input wire synthConfig_t           synthConfig,
	input wire logic [2*REF_COUNT-1:0] refModeSel,
	input wire logic                   customAInUse
);
	// ----------------------------------------
	// Write accepted with address and data together
	// ----------------------------------------
	wire logic       wTake = axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
		&& axiReq.wstrb[0] && axiReq.awaddr[11:9] == 3'h0;
	wire logic [6:0] wIdx  = axiReq.awaddr[8:2];
	wire logic [7:0] wByte = axiReq.wdata[7:0];

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	property p_mult_lo;
		wTake && wIdx == IDX_PROG_MULT_LO |=> synthConfig.progMultiplier[7:0] == $past(wByte);
	endproperty
	a_mult_lo: assert property (p_mult_lo) else $error("multiplier low byte wrong");
	property p_mult_hi;
		wTake && wIdx == IDX_PROG_MULT_HI |=> synthConfig.progMultiplier[13:8] == $past(wByte[5:0]);
	endproperty
	a_mult_hi: assert property (p_mult_hi) else $error("multiplier high bits wrong");
	property p_pfine_hi;
		wTake && wIdx == IDX_PROG_PDLY_HI |=> synthConfig.progPulseFine[15:8] == $past(wByte);
	endproperty
	a_pfine_hi: assert property (p_pfine_hi) else $error("pulse delay high byte wrong");
	property p_sfine_lo;
		wTake && wIdx == IDX_SDH_PDLY_LO |=> synthConfig.sdhPulseFine[7:0] == $past(wByte);
	endproperty
	a_sfine_lo: assert property (p_sfine_lo) else $error("sdh pulse delay low byte wrong");
	property p_sdh_div;
		wTake && wIdx == IDX_SDH_DIV |=> synthConfig.sdhDivider == $past(wByte) && axiRsp.bresp == RESP_OKAY;
	endproperty
	a_sdh_div: assert property (p_sdh_div) else $error("divider write wrong");
	property p_stat_wr;
		wTake && wIdx == IDX_LOCK_STATE |=> axiRsp.bvalid && axiRsp.bresp == RESP_SLVERR;
	endproperty
	a_stat_wr: assert property (p_stat_wr) else $error("status write not refused");
	property p_stat_rd;
		axiReq.arvalid && axiRsp.arready && axiReq.araddr[11:2] == 10'h28
			|=> axiRsp.rvalid && $onehot(axiRsp.rdata[2:0]) && axiRsp.rdata[31:3] == 29'h0;
	endproperty
	a_stat_rd: assert property (p_stat_rd) else $error("status read malformed");
	property p_custa;
		refModeSel[1:0] == 2'h1 || refModeSel[3:2] == 2'h1 || refModeSel[5:4] == 2'h1 |-> ##[0:1] customAInUse;
	endproperty
	a_custa: assert property (p_custa) else $error("custom A use flag low");

	c_stat_wr: cover property (wTake && wIdx == IDX_LOCK_STATE);
	c_read: cover property (axiRsp.rvalid && axiReq.rready);
	c_custa: cover property (customAInUse);
endmodule

bind synth_output_config_regs synth_output_config_regs_checker i_synth_output_config_regs_checker (
	.clk_sys(clk_sys), .resetn(resetn), .axiReq(axiReq), .axiRsp(axiRsp),
	.synthConfig(synthConfig), .refModeSel(refModeSel), .customAInUse(customAInUse));

// >>> tb/synth_output_config_regs_bench.sv
`timescale 1ns/1ps
module synth_output_config_regs_bench
	import synth_cfg_pkg::*;
;
	logic         clk_sys;
	logic         resetn;
	axiReq_t      axiReq;
	axiRsp_t      axiRsp;
	logic         lockedPin;
	logic         holdoverPin;
	synthConfig_t synthConfig;
	outputDrive_t outputDrive;
	logic [5:0]   refModeSel;
	logic         customAInUse;
	logic [8:0]   monitorCycles;
	int           failures;
	int           checked;
	int           seed;
	logic [7:0]   mem [128];
	logic [1:0]   bq [$];
	logic [33:0]  rq [$];
	// Index and reset value of each location
	localparam logic [15:0] RT [36] = '{16'h2804, 16'h2903, 16'h368f, 16'h370f, 16'h3800, 16'h3901,
		16'h3a00, 16'h3d00, 16'h3e05, 16'h3f83, 16'h4000, 16'h4100, 16'h4200, 16'h508f, 16'h510f, 16'h5242,
		16'h5300, 16'h5500, 16'h5605, 16'h5723, 16'h5800, 16'h5900, 16'h5a00, 16'h60a3, 16'h6153, 16'h63f5,
		16'h6500, 16'h6700, 16'h6800, 16'h6900, 16'h6a00, 16'h6b00, 16'h6c00, 16'h6d00, 16'h6e00, 16'h6f00};

	synth_output_config_regs i_synth_output_config_regs (.clk_sys(clk_sys), .resetn(resetn),
		.axiReq(axiReq), .axiRsp(axiRsp), .lockedPin(lockedPin), .holdoverPin(holdoverPin),
		.synthConfig(synthConfig), .outputDrive(outputDrive), .refModeSel(refModeSel),
		.customAInUse(customAInUse), .monitorCycles(monitorCycles));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic cmpBus(input logic [33:0] got, input logic [33:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: bus %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmpPort(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: port %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [11:0] ba(input logic [6:0] i);
		return {3'h0, i, 2'h0};
	endfunction

	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge clk_sys);
		bq.push_back(er);
		axiReq.awaddr <= a;
		axiReq.awvalid <= 1'b1;
		axiReq.wdata <= {24'h0, d};
		axiReq.wvalid <= 1'b1;
		axiReq.bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk_sys);
			if (axiReq.awvalid && axiRsp.awready) begin
				aw = 1'b1;
				axiReq.awvalid <= 1'b0;
			end
			if (axiReq.wvalid && axiRsp.wready) begin
				w = 1'b1;
				axiReq.wvalid <= 1'b0;
			end
		end
		while (!axiRsp.bvalid) @(posedge clk_sys);
		axiReq.bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge clk_sys);
		rq.push_back({er, 24'h0, d});
		axiReq.araddr <= a;
		axiReq.arvalid <= 1'b1;
		axiReq.rready <= 1'b1;
		do @(posedge clk_sys); while (!axiRsp.arready);
		axiReq.arvalid <= 1'b0;
		while (!axiRsp.rvalid) @(posedge clk_sys);
		axiReq.rready <= 1'b0;
	endtask

	// Answers are matched against the oldest note
	always @(posedge clk_sys) begin
		if (axiRsp.bvalid && axiReq.bready && bq.size() > 0) cmpBus(34'(axiRsp.bresp), 34'(bq.pop_front()));
		if (axiRsp.rvalid && axiReq.rready && rq.size() > 0) cmpBus({axiRsp.rresp, axiRsp.rdata}, rq.pop_front());
	end

	task automatic tblCheck();
		for (int k = 0; k < 36; k++) begin
			mem[RT[k][14:8]] = RT[k][7:0];
			rd(ba(RT[k][14:8]), RT[k][7:0], RESP_OKAY);
		end
	endtask

	task automatic portCheck();
		logic [7:0] m;
		logic [5:0] e;
		m = mem['h65];
		for (int i = 0; i < 3; i++) e[2*i +: 2] = m[2*i +: 2] == 2'h3 ? 2'h0 : m[2*i +: 2];
		cmpPort(refModeSel, e);
		cmpPort(synthConfig.progMultiplier, {mem['h39][5:0], mem['h38]});
		cmpPort(synthConfig.progPulseFine, {mem['h41], mem['h40]});
		cmpPort(synthConfig.sdhPulseFine, {mem['h59], mem['h58]});
		cmpPort({synthConfig.progPulseCoarse, synthConfig.sdhPulseCoarse}, {mem['h42], mem['h5a]});
		cmpPort(outputDrive, {mem['h36][0] & mem['h37][0], mem['h36][1] & mem['h37][1],
			mem['h50][0] & mem['h51][0], mem['h50][1] & mem['h51][1], mem['h60][0]});
		cmpPort({synthConfig.sdhDivider, synthConfig.diffRate}, {mem['h52], mem['h61]});
		cmpPort({synthConfig.progClkPhase, synthConfig.sdhClkPhase}, {mem['h3a], mem['h53]});
		cmpPort({synthConfig.progFineAlign, synthConfig.sdhFineAlign, synthConfig.fbFineAlign},
			{mem['h3d], mem['h55], mem['h63]});
		cmpPort({synthConfig.progPulseRate, synthConfig.progPulseStyle, synthConfig.sdhPulseRate,
			synthConfig.sdhPulseStyle}, {mem['h3e], mem['h3f], mem['h56], mem['h57]});
		cmpPort(customAInUse, m[1:0] == 2'h1 || m[3:2] == 2'h1 || m[5:4] == 2'h1);
		cmpPort({synthConfig.custAMultiplier, synthConfig.custAScmLow, synthConfig.custAScmHigh},
			{mem['h68][5:0], mem['h67], mem['h69], mem['h6a]});
		cmpPort({synthConfig.custACfmLow, synthConfig.custACfmHigh}, {mem['h6c], mem['h6b], mem['h6e], mem['h6d]});
		cmpPort(monitorCycles, 9'(mem['h6f]) + 9'h1);
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Cuts a hang short
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		wrap_up();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] d;
		axiReq = '0;
		axiReq.wstrb = 4'hf;
		resetn = 1'b0;
		lockedPin = 1'b0;
		holdoverPin = 1'b0;
		failures = 0;
		checked = 0;
		seed = 32'hefb2;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		tblCheck();
		// Random contents, status and reserved location left alone
		for (int r = 0; r < 3; r++) begin
			for (int k = 2; k < 36; k++) begin
				d = 8'($random(seed));
				mem[RT[k][14:8]] = d;
				wr(ba(RT[k][14:8]), d, RESP_OKAY);
			end
			for (int k = 2; k < 36; k++) rd(ba(RT[k][14:8]), mem[RT[k][14:8]], RESP_OKAY);
			repeat (2) @(posedge clk_sys);
			portCheck();
		end
		wr(ba(IDX_LOCK_STATE), 8'hff, RESP_SLVERR);
		rd(ba(7'h2a), 8'h00, RESP_SLVERR);
		axiReq.wstrb <= 4'h0;
		wr(ba(IDX_PROG_RUN), ~mem['h37], RESP_OKAY);
		axiReq.wstrb <= 4'hf;
		wr(12'h800 | ba(IDX_PROG_RUN), 8'h00, RESP_SLVERR);
		rd(ba(IDX_PROG_RUN), mem['h37], RESP_OKAY);
		lockedPin <= 1'b1;
		repeat (5) @(posedge clk_sys);
		rd(ba(IDX_LOCK_STATE), 8'h01, RESP_OKAY);
		lockedPin <= 1'b0;
		holdoverPin <= 1'b1;
		repeat (5) @(posedge clk_sys);
		rd(ba(IDX_LOCK_STATE), 8'h02, RESP_OKAY);
		holdoverPin <= 1'b0;
		resetn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		tblCheck();
		wrap_up();
	end
endmodule
